// >>> rtl/i2c_tx_pkg.sv
package i2c_tx_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] TXBUF_OFS  = 4'h0;
  localparam logic [3:0] CTRL_OFS   = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam logic [3:0] BAUD_OFS   = 4'hC;

  // control bits
  localparam int START_BIT   = 0;
  localparam int RESTART_BIT = 1;
  localparam int STOP_BIT    = 2;

  // status bits
  localparam int BF_BIT   = 0;
  localparam int IRQ_BIT  = 1;
  localparam int ACKS_BIT = 2;
  localparam int WRITE_COLLISION_FLAG_BIT = 3;
  localparam int COLL_BIT = 4;
  localparam int BUSY_BIT = 5;

  // reset values
  localparam logic [7:0] TXBUF_RST = 8'h00;
  localparam logic [7:0] BAUD_RST  = 8'h00;

  // bit index of the acknowledge slot and of the last data bit
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT      = 4'h8;

  // ----------------------------------------------------------------
  // carriers between domains
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CMD_BYTE, CMD_START, CMD_RESTART, CMD_STOP} cmd_kind_t;

  typedef struct packed {
    cmd_kind_t  kind;
    logic [7:0] data;
    logic [7:0] reload;
  } cmd_t;

  typedef struct packed {
    logic ack_status_flag;
    logic coll;
  } evt_t;

endpackage

// >>> rtl/i2c_master_tx.sv
`timescale 1ns/10ps
module i2c_master_tx (
  // system
  input  wire logic        clk,
  input  wire logic        reset_n,
  // link clock
  input  wire logic        linkClk,
  // wishbone slave
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // i2c pins
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic                wbHit;
  logic                wrEn;
  logic [31:0]         rdData;
  logic                ackQ;
  logic [31:0]         datQ;
  logic [7:0]          txBufQ;
  logic [7:0]          reloadQ;
  logic                startReqQ;
  logic                restartReqQ;
  logic                stopReqQ;
  logic                bufFullQ;
  logic                irqQ;
  logic                ackStatQ;
  logic                wcolQ;
  logic                collQ;
  logic                busyQ;
  logic                reqTogQ;
  i2c_tx_pkg::cmd_t    cmdQ;
  logic                wrBuf;
  logic                wrCtrl;
  logic                wrStat;
  logic                issue;
  i2c_tx_pkg::cmd_t    cmdD;

  assign wbHit  = wb_cyc_i & wb_stb_i & ~ackQ;
  assign wrEn   = wbHit & wb_we_i & wb_sel_i[0];
  assign wrBuf  = wrEn && (wb_adr_i == i2c_tx_pkg::TXBUF_OFS);
  assign wrCtrl = wrEn && (wb_adr_i == i2c_tx_pkg::CTRL_OFS);
  assign wrStat = wrEn && (wb_adr_i == i2c_tx_pkg::STATUS_OFS);

  always_comb begin
    rdData = 32'h0000_0000;
    if (wb_adr_i == i2c_tx_pkg::TXBUF_OFS) begin
      rdData[7:0] = txBufQ;
    end else if (wb_adr_i == i2c_tx_pkg::CTRL_OFS) begin
      rdData[i2c_tx_pkg::START_BIT]   = startReqQ;
      rdData[i2c_tx_pkg::RESTART_BIT] = restartReqQ;
      rdData[i2c_tx_pkg::STOP_BIT]    = stopReqQ;
    end else if (wb_adr_i == i2c_tx_pkg::STATUS_OFS) begin
      rdData[i2c_tx_pkg::BF_BIT]   = bufFullQ;
      rdData[i2c_tx_pkg::IRQ_BIT]  = irqQ;
      rdData[i2c_tx_pkg::ACKS_BIT] = ackStatQ;
      rdData[i2c_tx_pkg::WRITE_COLLISION_FLAG_BIT] = wcolQ;
      rdData[i2c_tx_pkg::COLL_BIT] = collQ;
      rdData[i2c_tx_pkg::BUSY_BIT] = busyQ;
    end else if (wb_adr_i == i2c_tx_pkg::BAUD_OFS) begin
      rdData[7:0] = reloadQ;
    end
  end

  // one wait state; unmapped offsets still ack and read zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ackQ <= 1'b0;
      datQ <= 32'h0000_0000;
    end else begin
      ackQ <= wbHit;
      if (wbHit) begin
        datQ <= rdData;
      end
    end
  end

  assign wb_ack_o = ackQ;
  assign wb_dat_o = datQ;

  // ----------------------------------------------------------------
  // event returns from the link domain
  // ----------------------------------------------------------------
  logic                doneTogQ;
  logic                eightTogQ;
  i2c_tx_pkg::evt_t    evtQ;
  logic [2:0]          doneSyncQ;
  logic [2:0]          eightSyncQ;
  logic                donePulse;
  logic                eightPulse;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      doneSyncQ  <= 3'h0;
      eightSyncQ <= 3'h0;
    end else begin
      doneSyncQ  <= {doneSyncQ[1:0], doneTogQ};
      eightSyncQ <= {eightSyncQ[1:0], eightTogQ};
    end
  end

  assign donePulse  = doneSyncQ[2] ^ doneSyncQ[1];
  assign eightPulse = eightSyncQ[2] ^ eightSyncQ[1];

  // ----------------------------------------------------------------
  // command issue: one command outstanding, held until it completes
  // ----------------------------------------------------------------
  always_comb begin
    issue       = 1'b0;
    cmdD        = cmdQ;
    cmdD.reload = reloadQ;
    cmdD.data   = wb_dat_i[7:0];
    if (!busyQ && wrBuf) begin
      issue     = 1'b1;
      cmdD.kind = i2c_tx_pkg::CMD_BYTE;
    end else if (!busyQ && wrCtrl) begin
      issue = |wb_dat_i[2:0];
      if (wb_dat_i[i2c_tx_pkg::START_BIT]) begin
        cmdD.kind = i2c_tx_pkg::CMD_START;
      end else if (wb_dat_i[i2c_tx_pkg::RESTART_BIT]) begin
        cmdD.kind = i2c_tx_pkg::CMD_RESTART;
      end else begin
        cmdD.kind = i2c_tx_pkg::CMD_STOP;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmdQ        <= '0;
      reqTogQ     <= 1'b0;
      busyQ       <= 1'b0;
      startReqQ   <= 1'b0;
      restartReqQ <= 1'b0;
      stopReqQ    <= 1'b0;
    end else begin
      if (issue) begin
        cmdQ    <= cmdD;
        reqTogQ <= ~reqTogQ;
        busyQ   <= 1'b1;
        startReqQ   <= cmdD.kind == i2c_tx_pkg::CMD_START;
        restartReqQ <= cmdD.kind == i2c_tx_pkg::CMD_RESTART;
        stopReqQ    <= cmdD.kind == i2c_tx_pkg::CMD_STOP;
      end else if (donePulse) begin
        busyQ       <= 1'b0;
        startReqQ   <= 1'b0;
        restartReqQ <= 1'b0;
        stopReqQ    <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // software visible registers and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txBufQ  <= i2c_tx_pkg::TXBUF_RST;
      reloadQ <= i2c_tx_pkg::BAUD_RST;
    end else begin
      if (wrBuf && !busyQ) begin
        txBufQ <= wb_dat_i[7:0];
      end
      if (wrEn && (wb_adr_i == i2c_tx_pkg::BAUD_OFS)) begin
        reloadQ <= wb_dat_i[7:0];
      end
    end
  end

  // flags set by hardware win over a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bufFullQ <= 1'b0;
      irqQ     <= 1'b0;
      ackStatQ <= 1'b0;
      wcolQ    <= 1'b0;
      collQ    <= 1'b0;
    end else begin
      if (wrBuf && !busyQ) begin
        bufFullQ <= 1'b1;
      end else if (eightPulse) begin
        bufFullQ <= 1'b0;
      end
      irqQ  <= donePulse | (irqQ & ~(wrStat & wb_dat_i[i2c_tx_pkg::IRQ_BIT]));
      wcolQ <= (wrBuf & busyQ)
               | (wcolQ & ~(wrStat & wb_dat_i[i2c_tx_pkg::WRITE_COLLISION_FLAG_BIT]));
      collQ <= (donePulse & evtQ.coll)
               | (collQ & ~(wrStat & wb_dat_i[i2c_tx_pkg::COLL_BIT]));
      if (donePulse && cmdQ.kind == i2c_tx_pkg::CMD_BYTE) begin
        ackStatQ <= evtQ.ack_status_flag;
      end
    end
  end

  // ----------------------------------------------------------------
  // link domain: synchronisers
  // ----------------------------------------------------------------
  typedef enum {L_IDLE, L_ST_HOLD, L_ST_LOW, L_BIT_LOW, L_BIT_HIGH,
                L_RS_SDA, L_RS_SCL, L_SP_LOW, L_SP_SCL, L_SP_SDA} lstate_t;

  logic [1:0]          sclSyncQ;
  logic [1:0]          sdaSyncQ;
  logic [1:0]          reqSyncQ;
  logic                reqSeenQ;
  logic                sclNow;
  logic                sdaNow;
  logic                newCmd;

  always_ff @(posedge linkClk or negedge reset_n) begin
    if (!reset_n) begin
      sclSyncQ <= 2'h3;
      sdaSyncQ <= 2'h3;
      reqSyncQ <= 2'h0;
      reqSeenQ <= 1'b0;
    end else begin
      sclSyncQ <= {sclSyncQ[0], sclIn};
      sdaSyncQ <= {sdaSyncQ[0], sdaIn};
      reqSyncQ <= {reqSyncQ[0], reqTogQ};
      reqSeenQ <= reqSyncQ[1];
    end
  end

  assign sclNow = sclSyncQ[1];
  assign sdaNow = sdaSyncQ[1];
  // command word has been stable for two link cycles when the toggle lands
  assign newCmd = reqSyncQ[1] ^ reqSeenQ;

  // ----------------------------------------------------------------
  // link domain: bit engine
  // ----------------------------------------------------------------
  lstate_t             stateQ;
  logic [8:0]          cntQ;
  logic [8:0]          load;
  logic                expire;
  logic [3:0]          bitQ;
  logic [7:0]          shQ;
  logic                highSeenQ;
  logic                sclOeQ;
  logic                sdaOeQ;
  logic                lowQ;

  // half period is 2*(reload+1) link cycles, full period 4*(reload+1)
  assign load   = {cmdQ.reload, 1'b1};
  assign expire = cntQ == 9'h000;

  always_ff @(posedge linkClk or negedge reset_n) begin
    if (!reset_n) begin
      stateQ    <= L_IDLE;
      cntQ      <= 9'h000;
      bitQ      <= 4'h0;
      shQ       <= 8'h00;
      highSeenQ <= 1'b0;
      sclOeQ    <= 1'b0;
      sdaOeQ    <= 1'b0;
      doneTogQ  <= 1'b0;
      eightTogQ <= 1'b0;
      evtQ      <= '0;
    end else begin
      case (stateQ)
        L_IDLE: begin
          if (newCmd) begin
            cntQ      <= load;
            evtQ.coll <= 1'b0;
            case (cmdQ.kind)
              i2c_tx_pkg::CMD_START: begin
                sdaOeQ <= 1'b1;
                stateQ <= L_ST_HOLD;
              end
              i2c_tx_pkg::CMD_RESTART: begin
                sdaOeQ <= 1'b0;
                sclOeQ <= 1'b1;
                stateQ <= L_RS_SDA;
              end
              i2c_tx_pkg::CMD_STOP: begin
                sdaOeQ <= 1'b1;
                sclOeQ <= 1'b1;
                stateQ <= L_SP_LOW;
              end
              default: begin
                sclOeQ <= 1'b1;
                shQ    <= cmdQ.data;
                bitQ   <= 4'h0;
                stateQ <= L_BIT_LOW;
              end
            endcase
          end
        end
        L_ST_HOLD: begin
          if (expire) begin
            sclOeQ <= 1'b1;
            cntQ   <= load;
            stateQ <= L_ST_LOW;
          end else begin
            cntQ <= cntQ - 9'h001;
          end
        end
        L_ST_LOW: begin
          if (expire) begin
            doneTogQ <= ~doneTogQ;
            stateQ   <= L_IDLE;
          end else begin
            cntQ <= cntQ - 9'h001;
          end
        end
        L_BIT_LOW: begin
          // data moves one link cycle after the fall, so the slave keeps its hold time
          if (cntQ == load) begin
            if (bitQ == i2c_tx_pkg::ACK_SLOT) begin
              sdaOeQ    <= 1'b0;
              eightTogQ <= ~eightTogQ;
            end else begin
              sdaOeQ <= ~shQ[7];
              shQ    <= {shQ[6:0], 1'b0};
            end
          end
          if (expire) begin
            sclOeQ <= 1'b0;
            cntQ   <= load;
            stateQ <= L_BIT_HIGH;
          end else begin
            cntQ <= cntQ - 9'h001;
          end
        end
        L_BIT_HIGH: begin
          // a slave stretching SCL freezes the high-time count
          if (sclNow && expire) begin
            sclOeQ <= 1'b1;
            cntQ   <= load;
            if (bitQ == i2c_tx_pkg::ACK_SLOT) begin
              evtQ.ack_status_flag <= sdaNow;
              doneTogQ     <= ~doneTogQ;
              stateQ       <= L_IDLE;
            end else begin
              bitQ   <= bitQ + 4'h1;
              stateQ <= L_BIT_LOW;
            end
          end else if (sclNow) begin
            cntQ <= cntQ - 9'h001;
          end
        end
        L_RS_SDA: begin
          if (expire) begin
            sclOeQ <= 1'b0;
            cntQ   <= load;
            stateQ <= L_RS_SCL;
          end else begin
            cntQ <= cntQ - 9'h001;
          end
        end
        L_RS_SCL: begin
          if (sclNow && expire) begin
            sdaOeQ <= 1'b1;
            cntQ   <= load;
            stateQ <= L_ST_HOLD;
          end else if (sclNow) begin
            cntQ <= cntQ - 9'h001;
          end
        end
        L_SP_LOW: begin
          if (!expire) begin
            cntQ <= cntQ - 9'h001;
          end else if (!sdaNow) begin
            sclOeQ    <= 1'b0;
            highSeenQ <= 1'b0;
            stateQ    <= L_SP_SCL;
          end
        end
        L_SP_SCL: begin
          if (!sclNow) begin
            if (highSeenQ) begin
              sdaOeQ    <= 1'b0;
              evtQ.coll <= 1'b1;
              doneTogQ  <= ~doneTogQ;
              stateQ    <= L_IDLE;
            end
          end else if (!highSeenQ) begin
            highSeenQ <= 1'b1;
            cntQ      <= load;
          end else if (expire) begin
            sdaOeQ <= 1'b0;
            cntQ   <= load;
            stateQ <= L_SP_SDA;
          end else begin
            cntQ <= cntQ - 9'h001;
          end
        end
        L_SP_SDA: begin
          if ((!sclNow && !sdaNow) || (expire && !sdaNow)) begin
            sclOeQ    <= 1'b0;
            evtQ.coll <= 1'b1;
            doneTogQ  <= ~doneTogQ;
            stateQ    <= L_IDLE;
          end else if (expire) begin
            doneTogQ <= ~doneTogQ;
            stateQ   <= L_IDLE;
          end else begin
            cntQ <= cntQ - 9'h001;
          end
        end
        default: begin
          stateQ <= L_IDLE;
        end
      endcase
    end
  end

  // open drain: only ever drive a low
  always_ff @(posedge linkClk or negedge reset_n) begin
    if (!reset_n) begin
      lowQ <= 1'b0;
    end else begin
      lowQ <= 1'b0;
    end
  end

  assign sclOe  = sclOeQ;
  assign sdaOe  = sdaOeQ;
  assign sclOut = lowQ;
  assign sdaOut = lowQ;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic highTick;
  assign highTick = (stateQ == L_BIT_HIGH) && sclNow && expire;

  property p_buf_write;
    @(posedge clk) disable iff (!reset_n)
      (wrBuf && !busyQ) |=> bufFullQ && busyQ && (txBufQ == $past(wb_dat_i[7:0]));
  endproperty
  a_buf_write: assert property (p_buf_write) else $error("buffer write not taken");

  property p_scl_low;
    @(posedge linkClk) disable iff (!reset_n)
      (stateQ == L_BIT_LOW) |-> sclOeQ;
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("SCL not low in low phase");

  property p_scl_high;
    @(posedge linkClk) disable iff (!reset_n)
      (stateQ == L_BIT_HIGH) ##1 (stateQ == L_BIT_HIGH) |-> !sclOeQ && $stable(sdaOeQ);
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("SDA moved while SCL high");

  property p_eighth;
    @(posedge linkClk) disable iff (!reset_n)
      (highTick && bitQ == i2c_tx_pkg::LAST_DATA_BIT)
        |=> ##1 (!sdaOeQ && sclOeQ && $changed(eightTogQ));
  endproperty
  a_eighth: assert property (p_eighth) else $error("SDA not released after bit 8");

  property p_ack_cap;
    @(posedge linkClk) disable iff (!reset_n)
      (highTick && bitQ == 4'h8) |=> evtQ.ack_status_flag == $past(sdaNow);
  endproperty
  a_ack_cap: assert property (p_ack_cap) else $error("acknowledge not captured");

  property p_park;
    @(posedge linkClk) disable iff (!reset_n)
      (highTick && bitQ == 4'h8) |=> (stateQ == L_IDLE) && sclOeQ && !sdaOeQ
        ##1 (sclOeQ && !sdaOeQ)[*2];
  endproperty
  a_park: assert property (p_park) else $error("bus not parked after ninth clock");

  property p_bit_order;
    @(posedge linkClk) disable iff (!reset_n)
      (stateQ == L_BIT_LOW && cntQ == load && bitQ < i2c_tx_pkg::ACK_SLOT)
        |=> sdaOeQ == !$past(shQ[7]);
  endproperty
  a_bit_order: assert property (p_bit_order) else $error("wrong bit shifted out");

  property p_write_collision_flag;
    @(posedge clk) disable iff (!reset_n)
      (wrBuf && busyQ) |=> wcolQ && $stable(txBufQ);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("write collision not flagged");

  property p_start;
    @(posedge linkClk) disable iff (!reset_n)
      (stateQ == L_IDLE && newCmd && cmdQ.kind == i2c_tx_pkg::CMD_START)
        |=> sdaOeQ && !sclOeQ ##1 (sdaOeQ && !sclOeQ);
  endproperty
  a_start: assert property (p_start) else $error("start hold violated");

  property p_stop_rel;
    @(posedge linkClk) disable iff (!reset_n)
      (stateQ == L_SP_LOW && expire && !sdaNow) |=> !sclOeQ && sdaOeQ && stateQ == L_SP_SCL;
  endproperty
  a_stop_rel: assert property (p_stop_rel) else $error("SCL not released in stop");

  property p_coll1;
    @(posedge linkClk) disable iff (!reset_n)
      (stateQ == L_SP_SDA && expire && !sdaNow) |=> evtQ.coll && !sclOeQ && !sdaOeQ;
  endproperty
  a_coll1: assert property (p_coll1) else $error("stop collision case 1 missed");

  property p_coll2;
    @(posedge linkClk) disable iff (!reset_n)
      (stateQ == L_SP_SCL && highSeenQ && !sclNow) |=> evtQ.coll && stateQ == L_IDLE && !sdaOeQ;
  endproperty
  a_coll2: assert property (p_coll2) else $error("stop collision case 2 missed");

  property p_baud;
    @(posedge linkClk) disable iff (!reset_n)
      (stateQ == L_BIT_LOW && expire) |=> cntQ == {cmdQ.reload, 1'b1};
  endproperty
  a_baud: assert property (p_baud) else $error("baud count not reloaded");

  c_byte: cover property (@(posedge linkClk) disable iff (!reset_n) highTick && bitQ == 4'h8);
  c_start: cover property (@(posedge linkClk) disable iff (!reset_n)
    stateQ == L_ST_LOW && expire);
  c_stop_ok: cover property (@(posedge linkClk) disable iff (!reset_n)
    stateQ == L_SP_SDA && expire && sdaNow && sclNow);
  c_stop_coll: cover property (@(posedge clk) disable iff (!reset_n) donePulse && evtQ.coll);

endmodule

// >>> bench/i2c_slave_model.sv
`timescale 1ns/10ps
module i2c_slave_model (
  // bus levels
  input  wire logic       scl,
  input  wire logic       sda,
  // bench control
  input  wire logic       ackEn,
  input  wire logic       collide,
  // pull-down and captured byte
  output logic            sdaLow,
  output logic      [7:0] rxByte
);
  // ----------------------------------------------------------------
  // byte receiver with acknowledge
  // ----------------------------------------------------------------
  logic [3:0] cnt    = 4'h0;
  logic       ackLow = 1'b0;

  // collide mimics a second master holding data low through a stop
  assign sdaLow = ackLow | collide;

  always @(negedge sda) begin
    if (scl) begin
      cnt <= 4'h0;
    end
  end

  always @(posedge scl) begin
    if (cnt < 4'h8) begin
      rxByte <= {rxByte[6:0], sda};
    end
    cnt <= (cnt < 4'h8) ? cnt + 4'h1 : 4'h9;
  end

  always @(negedge scl) begin
    if (cnt == 4'h8) begin
      ackLow <= ackEn;
    end
    if (cnt == 4'h9) begin
      ackLow <= 1'b0;
      cnt    <= 4'h0;
    end
  end
endmodule

// >>> bench/tb_i2c_master_tx.sv
`timescale 1ns/10ps
module tb_i2c_master_tx;
  logic        clk, reset_n, linkClk, we, cyc, stb, ack, ackEn, collide;
  logic        sclOut, sclOe, sdaOut, sdaOe, sdaLow, scl, sda, sclGrab;
  logic [3:0]  adr, sel;
  logic [31:0] dat, rdat, r;
  logic [7:0]  rxByte;
  logic [8:0]  rows [4] = '{9'h1A4, 9'h15A, 9'h0FF, 9'h100};
  int          failures, samples_checked, cycles;

  // open-drain wiring with pull-ups
  // sclGrab stands for a second master pulling the clock low
  assign scl = ~(sclOe | sclGrab);
  assign sda = ~(sdaOe | sdaLow);

  i2c_master_tx dut_u (.clk(clk), .reset_n(reset_n), .linkClk(linkClk), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe));
  i2c_slave_model slave_u (.scl(scl), .sda(sda), .ackEn(ackEn), .collide(collide),
    .sdaLow(sdaLow), .rxByte(rxByte));

  // ----------------------------------------------------------------
  // clocks, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #1.3;
    forever #3 linkClk = ~linkClk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // classic single cycle; the wait is open, only the timeout ends it
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    we  <= w;
    dat <= d;
    sel <= 4'hF;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic idle();
    repeat (8) @(posedge clk);
    do wb(i2c_tx_pkg::STATUS_OFS, 1'b0, 32'h0); while (r[i2c_tx_pkg::BUSY_BIT] !== 1'b0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {we, cyc, stb, ackEn, collide, sclGrab, adr, sel, dat, reset_n} = '0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    wb(i2c_tx_pkg::STATUS_OFS, 1'b0, 32'h0); chk(r, 32'h0);
    wb(i2c_tx_pkg::TXBUF_OFS, 1'b0, 32'h0); chk(r, {24'h0, i2c_tx_pkg::TXBUF_RST});
    wb(4'h2, 1'b0, 32'h0); chk(r, 32'h0);
    wb(i2c_tx_pkg::BAUD_OFS, 1'b1, 32'h2);
    wb(i2c_tx_pkg::CTRL_OFS, 1'b1, 32'h1 << i2c_tx_pkg::START_BIT);
    idle(); chk(r, 32'h2);
    wb(i2c_tx_pkg::STATUS_OFS, 1'b1, 32'h2);
    foreach (rows[i]) begin
      ackEn <= rows[i][8];
      wb(i2c_tx_pkg::TXBUF_OFS, 1'b1, {24'h0, rows[i][7:0]});
      wb(i2c_tx_pkg::STATUS_OFS, 1'b0, 32'h0); chk(r & 32'h21, 32'h21);
      idle(); chk({24'h0, rxByte}, {24'h0, rows[i][7:0]});
      chk(r, rows[i][8] ? 32'h2 : 32'h6);
      chk({30'h0, scl, sdaOe}, 32'h0);
      chk({30'h0, sclOut, sdaOut}, 32'h0);
      wb(i2c_tx_pkg::STATUS_OFS, 1'b1, 32'h2);
    end
    // second write lands while the first byte is still shifting
    wb(i2c_tx_pkg::TXBUF_OFS, 1'b1, 32'h3C);
    wb(i2c_tx_pkg::TXBUF_OFS, 1'b1, 32'hC3);
    wb(i2c_tx_pkg::TXBUF_OFS, 1'b0, 32'h0); chk(r, 32'h3C);
    idle(); chk(r, 32'hA);
    chk({24'h0, rxByte}, 32'h3C);
    wb(i2c_tx_pkg::STATUS_OFS, 1'b1, 32'hA);
    // repeated start leaves both lines held low
    wb(i2c_tx_pkg::CTRL_OFS, 1'b1, 32'h1 << i2c_tx_pkg::RESTART_BIT);
    idle(); chk(r, 32'h2);
    chk({30'h0, scl, sda}, 32'h0);
    wb(i2c_tx_pkg::STATUS_OFS, 1'b1, 32'h2);
    wb(i2c_tx_pkg::CTRL_OFS, 1'b1, 32'h1 << i2c_tx_pkg::STOP_BIT);
    idle(); chk(r, 32'h2);
    chk({30'h0, scl, sda}, 32'h3);
    wb(i2c_tx_pkg::STATUS_OFS, 1'b1, 32'h2);
    wb(i2c_tx_pkg::CTRL_OFS, 1'b1, 32'h1 << i2c_tx_pkg::START_BIT);
    idle();
    wb(i2c_tx_pkg::STATUS_OFS, 1'b1, 32'h2);
    collide <= 1'b1;
    wb(i2c_tx_pkg::CTRL_OFS, 1'b1, 32'h1 << i2c_tx_pkg::STOP_BIT);
    idle(); chk(r & 32'h12, 32'h12);
    chk({30'h0, sclOe, sdaOe}, 32'h0);
    collide <= 1'b0;
    wb(i2c_tx_pkg::STATUS_OFS, 1'b1, 32'h12);
    // slow stop so the clock can be grabbed while it is counted high
    wb(i2c_tx_pkg::BAUD_OFS, 1'b1, 32'h20);
    wb(i2c_tx_pkg::CTRL_OFS, 1'b1, 32'h1 << i2c_tx_pkg::START_BIT);
    idle();
    wb(i2c_tx_pkg::STATUS_OFS, 1'b1, 32'h2);
    wb(i2c_tx_pkg::CTRL_OFS, 1'b1, 32'h1 << i2c_tx_pkg::STOP_BIT);
    @(posedge scl);
    repeat (4) @(posedge clk);
    sclGrab <= 1'b1;
    idle(); chk(r, 32'h12);
    chk({30'h0, sclOe, sdaOe}, 32'h0);
    sclGrab <= 1'b0;
    wb(i2c_tx_pkg::STATUS_OFS, 1'b1, 32'h12);
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    wb(i2c_tx_pkg::BAUD_OFS, 1'b0, 32'h0); chk(r, {24'h0, i2c_tx_pkg::BAUD_RST});
    give_verdict();
  end
endmodule
